// ==== rtl/cbr_pkg.sv ====
// Package with constants, states and carrier types of the bus shell
package cbr_pkg;

  // ****************************************************************
  // Memory map
  // ****************************************************************
  localparam logic [15:0] PORT_DIR_ADDR   = 16'h0000;
  localparam logic [15:0] PORT_LATCH_ADDR = 16'h0001;
  localparam logic [6:0]  INT_PAGE_TAG    = 7'h00;   // pages 0 and 1
  localparam logic [7:0]  STACK_PAGE      = 8'h01;
  localparam int          RAM_DEPTH       = 256;
  localparam int          RAM_AW          = 8;

  // ****************************************************************
  // Vectors and sequencing
  // ****************************************************************
  localparam logic [15:0] VEC_RST_LO  = 16'hfffc;
  localparam logic [15:0] VEC_RST_HI  = 16'hfffd;
  localparam logic [15:0] VEC_IRQ_LO  = 16'hfffe;
  localparam logic [15:0] VEC_IRQ_HI  = 16'hffff;
  localparam logic [2:0]  INIT_CYCLES = 3'h6;
  localparam logic [7:0]  PUSH_DEPTH  = 8'h03;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  PORT_DIR_RST   = 8'h00;
  localparam logic [7:0]  PORT_LATCH_RST = 8'h00;
  localparam logic [15:0] ADDR_RST       = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    S_HOLD, S_INIT, S_VLO, S_VHI, S_RUN, S_CORE,
    S_PUSH_H, S_PUSH_L, S_PUSH_P, S_IVLO, S_IVHI
  } cbr_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
  } cbr_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rw;     // high = read
  } cbr_bus_t;

endpackage

// ==== rtl/cbr_ram.sv ====
// Internal page of static RAM with registered read data
`timescale 1ns/10ps
module cbr_ram
  import cbr_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_we,
  input  wire logic [RAM_AW-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  output logic      [7:0]        o_rdata
);

  logic [7:0] mem [RAM_DEPTH];

  // Write and registered read; no reset, contents are undefined at power up
  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule

// ==== rtl/cbr_port.sv ====
// Eight-bit I/O port with per-bit direction register
`timescale 1ns/10ps
module cbr_port
  import cbr_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_we,
  input  wire logic       i_sel_dir,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_pins_in,
  output logic      [7:0] o_pins_out,
  output logic      [7:0] o_pins_oe,
  output logic      [7:0] o_rdata
);

  // ****************************************************************
  // Read selection
  // ****************************************************************
  // Input bits read the pin, output bits read back the latch
  wire [7:0] pin_view = (o_pins_oe & o_pins_out) | (~o_pins_oe & i_pins_in);
  wire [7:0] rd_sel   = i_sel_dir ? o_pins_oe : pin_view;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Direction doubles as the pin enable, latch as the pin value
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_pins_oe  <= PORT_DIR_RST;
      o_pins_out <= PORT_LATCH_RST;
      o_rdata    <= 8'h00;
    end
    else
    begin
      if (i_we && i_sel_dir)
      begin
        o_pins_oe <= i_wdata;
      end
      if (i_we && !i_sel_dir)
      begin
        o_pins_out <= i_wdata;
      end
      o_rdata <= rd_sel;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  property p_dir_write;
    i_we && i_sel_dir |=> o_pins_oe == $past(i_wdata);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction register did not take written value");

  property p_latch_kept;
    i_we && i_sel_dir |=> o_pins_out == $past(o_pins_out);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("direction write disturbed the output latch");

endmodule

// ==== rtl/cbr_top.sv ====
// Reset, interrupt entry and bus shell around the internal RAM and port
`timescale 1ns/10ps
// Summary of operation
// - One RAM page answers at pages 0 and 1
// - Direction at 0000, output latch at 0001
// - Each port bit has its own direction
// - No writes while init line is low
// - Rising init line starts reset sequence at once
// - After six cycles set mask, fetch FFFC/FFFD
// - Interrupt evaluated only at instruction end
// - Interrupt taken only when mask flag clear
// - Push PC and status, then set mask
// - Load PC from FFFE/FFFF after push
// - Address bus drive follows enable, one cycle late
// - Read/write line high except write cycles
// - Data bus driven on writes, received otherwise
// - Sixteen-bit three-state address output
module cbr_top
  import cbr_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_init_line_n,
  input  wire logic        i_irq_n,
  input  wire logic        i_addr_bus_drive_enable,
  input  wire logic [7:0]  i_data_lines_in,
  input  wire logic [7:0]  i_port_pins_in,
  input  wire logic        i_core_valid,
  input  wire cbr_req_t    i_core_req,
  input  wire logic        i_instr_end,
  input  wire logic        i_mask_set,
  input  wire logic        i_mask_clr,
  input  wire logic [15:0] i_core_pc,
  input  wire logic [7:0]  i_core_sp,
  input  wire logic [7:0]  i_core_status,
  output logic [15:0]      o_addr,
  output logic             o_addr_oe,
  output logic             o_rw,
  output logic [7:0]       o_data_lines_out,
  output logic             o_data_lines_oe,
  output logic [7:0]       o_port_pins_out,
  output logic [7:0]       o_port_pins_oe,
  output logic             o_core_ack,
  output logic [7:0]       o_core_rdata,
  output logic             o_irq_mask,
  output logic             o_vec_load,
  output logic             o_vec_is_irq,
  output logic [15:0]      o_pc_new,
  output logic             o_running
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Pages 0 and 1 fold onto one page, so only bits 15..9 are checked
  function automatic logic is_internal(input logic [15:0] a);
    is_internal = (a[15:9] == INT_PAGE_TAG);
  endfunction

  function automatic logic is_port(input logic [15:0] a);
    is_port = (a == PORT_DIR_ADDR) || (a == PORT_LATCH_ADDR);
  endfunction

  // Address, data and direction of the bus cycle that a state performs
  // Idle states keep the current address, handed in as an argument so the
  // net that calls this follows every move of the address register
  function automatic cbr_bus_t bus_setup(input cbr_state_t s,
                                         input cbr_req_t   rq,
                                         input logic [15:0] pc,
                                         input logic [7:0] sp,
                                         input logic [7:0] stat,
                                         input logic [15:0] cur);
    cbr_bus_t b;
    b = '{addr: cur, wdata: 8'h00, rw: 1'b1};
    case (s)
      S_VLO:    b.addr = VEC_RST_LO;
      S_VHI:    b.addr = VEC_RST_HI;
      S_CORE:   b = '{addr: rq.addr, wdata: rq.wdata, rw: !rq.we};
      S_PUSH_H: b = '{addr: {STACK_PAGE, sp}, wdata: pc[15:8], rw: 1'b0};
      S_PUSH_L: b = '{addr: {STACK_PAGE, sp - 8'h01}, wdata: pc[7:0],
                      rw: 1'b0};
      S_PUSH_P: b = '{addr: {STACK_PAGE, sp - 8'h02}, wdata: stat,
                      rw: 1'b0};
      S_IVLO:   b.addr = VEC_IRQ_LO;
      S_IVHI:   b.addr = VEC_IRQ_HI;
      default:  b.rw = 1'b1;
    endcase
    bus_setup = b;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  cbr_state_t  st;
  cbr_state_t  next_st;
  logic        ph;
  logic [2:0]  cnt;
  logic        init_q;
  logic [15:0] pc_q;
  logic [7:0]  sp_q;
  logic [7:0]  stat_q;
  logic [7:0]  ram_q;
  logic [7:0]  port_q;

  // ****************************************************************
  // Control decode
  // ****************************************************************
  // Rise of the init line; reset clears init_q so release counts too
  wire init_rise = i_init_line_n && !init_q;
  // Request sampled only at the instruction boundary
  wire take_irq  = (st == S_RUN) && i_instr_end && !i_irq_n
                   && !o_irq_mask;
  wire bus_state = (st == S_VLO) || (st == S_VHI) || (st == S_CORE)
                   || (st == S_PUSH_H) || (st == S_PUSH_L)
                   || (st == S_PUSH_P) || (st == S_IVLO)
                   || (st == S_IVHI);
  wire step_done = bus_state && ph;
  wire next_ph   = (next_st == st) && bus_state && !ph;
  wire [15:0] pc_src   = (st == S_RUN) ? i_core_pc : pc_q;
  wire [7:0]  sp_src   = (st == S_RUN) ? i_core_sp : sp_q;
  wire [7:0]  stat_src = (st == S_RUN) ? i_core_status : stat_q;
  wire cbr_bus_t next_bus = bus_setup(next_st, i_core_req, pc_src,
                                      sp_src, stat_src, o_addr);
  wire changing  = (next_st != st);
  wire next_rw   = changing ? next_bus.rw : (o_rw || !bus_state);
  wire int_sel   = is_internal(o_addr);
  wire port_sel  = is_port(o_addr);
  // A falling init line blocks the internal write of the current cycle too
  wire int_we    = bus_state && !ph && !o_rw && i_init_line_n;
  // Internal space answers reads; external data otherwise
  wire [7:0] rd_data = port_sel ? port_q
                     : int_sel  ? ram_q : i_data_lines_in;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Low init line overrides everything and parks the bus in read
  always_comb
  begin
    next_st = st;
    case (st)
      S_HOLD:   next_st = S_HOLD;
      S_INIT:   if (cnt == INIT_CYCLES - 3'h1) next_st = S_VLO;
      S_VLO:    if (ph) next_st = S_VHI;
      S_VHI:    if (ph) next_st = S_RUN;
      S_RUN:
      begin
        if (take_irq)
          next_st = S_PUSH_H;
        else if (i_core_valid)
          next_st = S_CORE;
      end
      S_CORE:   if (ph) next_st = S_RUN;
      S_PUSH_H: if (ph) next_st = S_PUSH_L;
      S_PUSH_L: if (ph) next_st = S_PUSH_P;
      S_PUSH_P: if (ph) next_st = S_IVLO;
      S_IVLO:   if (ph) next_st = S_IVHI;
      S_IVHI:   if (ph) next_st = S_RUN;
      default:  next_st = S_HOLD;
    endcase
    if (!i_init_line_n)
      next_st = S_HOLD;
    else if (init_rise)
      next_st = S_INIT;
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st     <= S_HOLD;
      ph     <= 1'b0;
      cnt    <= 3'h0;
      init_q <= 1'b0;
    end
    else
    begin
      st     <= next_st;
      ph     <= next_ph;
      cnt    <= (st == S_INIT) ? cnt + 3'h1 : 3'h0;
      init_q <= i_init_line_n;
    end
  end

  // Push sources held for the whole entry, the core may move on
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pc_q   <= 16'h0000;
      sp_q   <= 8'h00;
      stat_q <= 8'h00;
    end
    else if (st == S_RUN)
    begin
      pc_q   <= i_core_pc;
      sp_q   <= i_core_sp;
      stat_q <= i_core_status;
    end
  end

  // ****************************************************************
  // Bus pins
  // ****************************************************************
  // Data drive follows a write cycle exactly, never in hold
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_addr           <= ADDR_RST;
      o_rw             <= 1'b1;
      o_data_lines_out <= 8'h00;
      o_data_lines_oe  <= 1'b0;
      o_addr_oe        <= 1'b0;
    end
    else
    begin
      o_addr           <= changing ? next_bus.addr : o_addr;
      o_data_lines_out <= changing ? next_bus.wdata : o_data_lines_out;
      o_rw             <= next_rw;
      o_data_lines_oe  <= !next_rw;
      o_addr_oe        <= i_addr_bus_drive_enable;
    end
  end

  // ****************************************************************
  // Results to the core
  // ****************************************************************
  // Mask sets beat a clear from the core in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_core_ack   <= 1'b0;
      o_core_rdata <= 8'h00;
      o_irq_mask   <= 1'b1;
      o_vec_load   <= 1'b0;
      o_vec_is_irq <= 1'b0;
      o_pc_new     <= 16'h0000;
      o_running    <= 1'b0;
    end
    else
    begin
      o_core_ack <= (st == S_CORE) && ph;
      o_vec_load <= ((st == S_VHI) || (st == S_IVHI)) && ph;
      o_running  <= (next_st != S_HOLD) && (next_st != S_INIT);
      if ((st == S_CORE) && ph)
        o_core_rdata <= rd_data;
      if (((st == S_VLO) || (st == S_IVLO)) && ph)
        o_pc_new[7:0] <= rd_data;
      if (((st == S_VHI) || (st == S_IVHI)) && ph)
      begin
        o_pc_new[15:8] <= rd_data;
        o_vec_is_irq   <= (st == S_IVHI);
      end
      if (((st == S_INIT) && (next_st == S_VLO))
          || ((st == S_PUSH_P) && ph))
        o_irq_mask <= 1'b1;
      else if (st == S_RUN && i_mask_set)
        o_irq_mask <= 1'b1;
      else if (st == S_RUN && i_mask_clr)
        o_irq_mask <= 1'b0;
    end
  end

  // ****************************************************************
  // Internal memory and port
  // ****************************************************************
  cbr_ram u_ram (
    .i_clk_sys (i_clk_sys),
    .i_we      (int_we && int_sel && !port_sel),
    .i_addr    (o_addr[RAM_AW-1:0]),
    .i_wdata   (o_data_lines_out),
    .o_rdata   (ram_q)
  );

  cbr_port u_port (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_we       (int_we && port_sel),
    .i_sel_dir  (o_addr == PORT_DIR_ADDR),
    .i_wdata    (o_data_lines_out),
    .i_pins_in  (i_port_pins_in),
    .o_pins_out (o_port_pins_out),
    .o_pins_oe  (o_port_pins_oe),
    .o_rdata    (port_q)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  property p_hold_read;
    !i_init_line_n |=> o_rw && !o_data_lines_oe;
  endproperty
  a_hold_read: assert property (p_hold_read)
    else $error("write activity while init line low");

  property p_rise_init;
    $rose(i_init_line_n) |=> st == S_INIT;
  endproperty
  a_rise_init: assert property (p_rise_init)
    else $error("init rise did not start the sequence");

  property p_init_vec;
    $rose(i_init_line_n) ##1 i_init_line_n [*6]
      |=> o_irq_mask && st == S_VLO && o_addr == VEC_RST_LO;
  endproperty
  a_init_vec: assert property (p_init_vec)
    else $error("reset vector fetch not six cycles after rise");

  property p_vec_hi;
    st == S_VLO && ph && i_init_line_n |=> o_addr == VEC_RST_HI;
  endproperty
  a_vec_hi: assert property (p_vec_hi)
    else $error("reset vector high byte not fetched");

  property p_masked;
    st == S_RUN && (o_irq_mask || !i_instr_end) |=> st != S_PUSH_H;
  endproperty
  a_masked: assert property (p_masked)
    else $error("interrupt entered while masked or mid instruction");

  property p_take;
    take_irq && i_init_line_n
      |=> st == S_PUSH_H && !o_rw && o_addr == {STACK_PAGE, $past(i_core_sp)};
  endproperty
  a_take: assert property (p_take)
    else $error("interrupt entry did not push to the stack");

  property p_push_vec;
    st == S_PUSH_P && ph && i_init_line_n
      |=> o_irq_mask && o_addr == VEC_IRQ_LO ##2 o_addr == VEC_IRQ_HI;
  endproperty
  a_push_vec: assert property (p_push_vec)
    else $error("interrupt vector not fetched after push");

  property p_addr_oe;
    i_addr_bus_drive_enable != o_addr_oe |=> o_addr_oe != $past(o_addr_oe);
  endproperty
  a_addr_oe: assert property (p_addr_oe)
    else $error("address enable not followed");

  property p_rw_oe;
    o_data_lines_oe == !o_rw;
  endproperty
  a_rw_oe: assert property (p_rw_oe)
    else $error("data drive disagrees with read/write line");

endmodule

// ==== sim/cbr_mem_model.sv ====
// Behavioural system memory that sits on the far side of the shell's bus
`timescale 1ns/10ps
module cbr_mem_model
  import cbr_pkg::*;
#(
  parameter logic [15:0] RST_TARGET = 16'h2000,
  parameter logic [15:0] IRQ_TARGET = 16'h3c00
)
(
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_addr_oe,
  input  wire logic        i_rw,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_data_oe,
  output logic      [7:0]  o_data_lines
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic [7:0] rd_q;

  // Vectors preset; everything else unknown until written
  initial
  begin
    last = 8'h00;
    mem[VEC_RST_LO] = RST_TARGET[7:0];
    mem[VEC_RST_HI] = RST_TARGET[15:8];
    mem[VEC_IRQ_LO] = IRQ_TARGET[7:0];
    mem[VEC_IRQ_HI] = IRQ_TARGET[15:8];
  end

  // Unselected lines toggle so a stale value never looks valid
  assign rd_q = mem[i_addr];
  assign o_data_lines = i_data_oe ? i_wdata :
                        (i_addr_oe && i_rw) ? rd_q : ~last;

  // Store only when selected and the shell says write
  always @(posedge i_clk_sys)
  begin
    last <= o_data_lines;
    if (i_addr_oe && !i_rw && i_data_oe)
      mem[i_addr] <= i_wdata;
  end
endmodule

// ==== sim/cbr_top_bench.sv ====
// Self-checking bench for the bus shell and its memory partner
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      err_total++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module cbr_top_bench
  import cbr_pkg::*;
;
  localparam logic [15:0] RST_T = 16'h20c4;
  localparam logic [15:0] IRQ_T = 16'h3c81;
  logic        i_clk_sys = 1'b0;
  logic        i_reset   = 1'b1;
  logic        init_n    = 1'b0;
  logic        irq_n     = 1'b1;
  logic        aben      = 1'b1;
  logic [7:0]  pins_in   = 8'h00;
  logic        valid     = 1'b0;
  cbr_req_t    req       = '0;
  logic        iend      = 1'b0;
  logic        mset      = 1'b0;
  logic        mclr      = 1'b0;
  logic [15:0] pc        = 16'h1234;
  logic [7:0]  sp        = 8'hff;
  logic [7:0]  stat      = 8'h5a;
  logic [15:0] addr, pcnew;
  logic [7:0]  dbus, dout, pout, poe, rdata;
  logic        addr_oe, rw, doe, ack, mask, vload, visirq, running;
  int          err_total = 0;
  int          n_compared = 0;

  // ****************************************************************
  // Clock, design and partner
  // ****************************************************************
  always #50 i_clk_sys = ~i_clk_sys;

  cbr_top dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_init_line_n(init_n),
    .i_irq_n(irq_n), .i_addr_bus_drive_enable(aben),
    .i_data_lines_in(dbus), .i_port_pins_in(pins_in),
    .i_core_valid(valid), .i_core_req(req), .i_instr_end(iend),
    .i_mask_set(mset), .i_mask_clr(mclr), .i_core_pc(pc),
    .i_core_sp(sp), .i_core_status(stat), .o_addr(addr),
    .o_addr_oe(addr_oe), .o_rw(rw), .o_data_lines_out(dout),
    .o_data_lines_oe(doe), .o_port_pins_out(pout),
    .o_port_pins_oe(poe), .o_core_ack(ack), .o_core_rdata(rdata),
    .o_irq_mask(mask), .o_vec_load(vload), .o_vec_is_irq(visirq),
    .o_pc_new(pcnew), .o_running(running));

  cbr_mem_model #(.RST_TARGET(RST_T), .IRQ_TARGET(IRQ_T)) u_mem (
    .i_clk_sys(i_clk_sys), .i_addr(addr), .i_addr_oe(addr_oe),
    .i_rw(rw), .i_wdata(dout), .i_data_oe(doe), .o_data_lines(dbus));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Inputs always move 10 ns after the edge, away from sampling
  task automatic tick();
    @(posedge i_clk_sys);
    #10;
  endtask

  // One core access; valid held until ack, dropped with it
  task automatic access(input logic [15:0] a, input logic we,
                        input logic [7:0] wd, output logic [7:0] rd);
    int n;
    begin
      req = '{addr: a, wdata: wd, we: we};
      valid = 1'b1;
      n = 0;
      while (ack !== 1'b1 && n < 8)
      begin
        tick();
        n++;
        if (n == 1)
        begin
          `CHK("rw", !we, rw)
          `CHK("data_oe", we, doe)
          `CHK("addr_oe", aben, addr_oe)
          if (aben)
            `CHK("addr", a, addr)
        end
      end
      `CHK("ack_lat", 3, n)
      rd = rdata;
      valid = 1'b0;
      tick();
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] ex);
    logic [7:0] d;
    begin
      access(a, 1'b0, 8'h00, d);
      `CHK("rdata", ex, d)
    end
  endtask

  // Hold the init line low with a write pending, then boot
  task automatic boot();
    int n;
    begin
      req = '{addr: 16'h0042, wdata: 8'hee, we: 1'b1};
      valid = 1'b1;
      init_n = 1'b0;
      repeat (4)
      begin
        tick();
        `CHK("rw_hold", 1'b1, rw)
        `CHK("running", 1'b0, running)
      end
      valid = 1'b0;
      init_n = 1'b1;
      n = 0;
      while (vload !== 1'b1 && n < 40)
      begin
        tick();
        n++;
        if (n == 7)
          `CHK("vec_lo", VEC_RST_LO, addr)
        if (n == 9)
          `CHK("vec_hi", VEC_RST_HI, addr)
      end
      `CHK("boot_lat", 11, n)
      `CHK("pc_rst", RST_T, pcnew)
      `CHK("mask_rst", 1'b1, mask)
      `CHK("is_irq", 1'b0, visirq)
      `CHK("running_on", 1'b1, running)
      tick();
    end
  endtask

  task automatic ram_test();
    logic [7:0] d;
    begin
      access(16'h0042, 1'b1, 8'ha5, d);
      rchk(16'h0142, 8'ha5);
      access(16'h01f0, 1'b1, 8'h3c, d);
      rchk(16'h00f0, 8'h3c);
    end
  endtask

  task automatic port_test();
    logic [7:0] d;
    begin
      rchk(PORT_DIR_ADDR, 8'h00);
      access(PORT_DIR_ADDR, 1'b1, 8'h0f, d);
      access(PORT_LATCH_ADDR, 1'b1, 8'ha5, d);
      `CHK("pins_oe", 8'h0f, poe)
      `CHK("pins_out", 8'ha5, pout)
      pins_in = 8'h3c;
      rchk(PORT_LATCH_ADDR, 8'h35);
      rchk(PORT_DIR_ADDR, 8'h0f);
    end
  endtask

  // External write and read-back, then one write with the bus given away
  task automatic ext_test();
    logic [7:0] d;
    begin
      access(16'h8000, 1'b1, 8'h5a, d);
      `CHK("ext_mem", 8'h5a, u_mem.mem[16'h8000])
      rchk(16'h8000, 8'h5a);
      aben = 1'b0;
      tick();
      tick();
      `CHK("addr_off", 1'b0, addr_oe)
      access(16'h9000, 1'b1, 8'h77, d);
      aben = 1'b1;
      tick();
      tick();
      `CHK("addr_on", 1'b1, addr_oe)
    end
  endtask

  task automatic irq_test();
    int n;
    begin
      irq_n = 1'b0;
      iend = 1'b1;
      tick();
      iend = 1'b0;
      repeat (16)
      begin
        tick();
        `CHK("masked", 1'b0, vload)
      end
      // Set and clear in one cycle: the set must win
      mset = 1'b1;
      mclr = 1'b1;
      tick();
      mset = 1'b0;
      mclr = 1'b0;
      `CHK("set_wins", 1'b1, mask)
      mclr = 1'b1;
      tick();
      mclr = 1'b0;
      tick();
      `CHK("mask_clr", 1'b0, mask)
      repeat (8)
      begin
        tick();
        `CHK("no_bound", 1'b0, vload)
      end
      iend = 1'b1;
      n = 0;
      while (vload !== 1'b1 && n < 40)
      begin
        tick();
        iend = 1'b0;
        n++;
      end
      `CHK("irq_lat", 11, n)
      `CHK("pc_irq", IRQ_T, pcnew)
      `CHK("is_irq", 1'b1, visirq)
      `CHK("mask_set", 1'b1, mask)
      `CHK("push_hi", 8'h12, u_mem.mem[16'h01ff])
      `CHK("push_lo", 8'h34, u_mem.mem[16'h01fe])
      irq_n = 1'b1;
      tick();
      rchk(16'h00fd, 8'h5a);
    end
  endtask

  task automatic test_done();
    $display("Compared %0d values, %0d mismatches", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence; a second boot checks the init line mid-run
  initial
  begin
    repeat (16) tick();
    i_reset = 1'b0;
    boot();
    `CHK("dir_rst", 8'h00, poe)
    `CHK("latch_rst", 8'h00, pout)
    ram_test();
    port_test();
    ext_test();
    irq_test();
    boot();
    test_done();
  end

  // Whole run is about 150 cycles; twenty times that means a hang
  initial
  begin
    #(100 * 3000);
    err_total++;
    test_done();
  end
endmodule
